// ==== verilog/oscillator_output_gating.sv ====
// Overview of operation
// RULE_01: after power-up or power-down release, stabilization waits until output_enable is high.
// RULE_02: output_enable dropped during stabilization keeps the gated output low afterwards.
// RULE_03: with external reference selected, stabilization counts external input clock periods.
// RULE_04: primary output ignores enable, but never starts while enable held low at power-up.
// RULE_05: both outputs rise first within 256 master periods of power-up or release; the code counts from stabilization start, once output_enable is high.
// RULE_06: source switch inserts a low break of at least half an internal period.
// RULE_07: output_enable changes take effect only at divided clock rises, no short phases.
`timescale 1ns/10ps
`default_nettype none
module oscillator_output_gating (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic power_down_n,
    input wire logic output_enable,
    input wire logic reference_select_n,
    input wire logic reference_input,
    output logic primary_clock_out,
    output logic gated_clock_out,
    output var osc_gating_pkg::state_t phase_state
);
    import osc_gating_pkg::*;

    divider_if prim_if ();
    divider_if div_if ();

    state_t state;
    state_t next_state;
    logic [7:0] int_cnt;
    logic [7:0] next_int_cnt;
    logic int_phase;
    logic next_int_phase;
    logic ref_prev;
    logic sel_ext;
    logic next_sel_ext;
    logic [8:0] stab_count;
    logic [8:0] next_stab_count;
    logic [7:0] break_cnt;
    logic [7:0] next_break_cnt;
    logic gate_en;
    logic next_gate_en;
    logic next_primary;
    logic next_gated;
    logic int_tick;
    logic ext_tick;
    logic master_tick;
    logic req_ext;
    logic req_tick;

    assign req_ext = !reference_select_n;
    assign int_tick = (int_cnt == INT_HALF_CYCLES - 8'h01) && !int_phase;
    assign ext_tick = reference_input && !ref_prev;
    assign master_tick = sel_ext ? ext_tick : int_tick; // see RULE_03
    assign req_tick = req_ext ? ext_tick : int_tick;

    assign prim_if.tick = master_tick;
    assign div_if.tick = master_tick;
    assign prim_if.clear = (state != ST_RUN);
    assign div_if.clear = (state != ST_RUN);

    tick_divider #(.HALF(PRIMARY_HALF)) u_primary (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .port(prim_if)
    );

    tick_divider #(.HALF(DIVIDED_HALF)) u_divided (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .port(div_if)
    );

    // internal oscillator model
    always_comb
    begin
        next_int_cnt = int_cnt + 8'h01;
        next_int_phase = int_phase;
        if (int_cnt == INT_HALF_CYCLES - 8'h01)
        begin
            next_int_cnt = 8'h00;
            next_int_phase = !int_phase;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            int_cnt <= 8'h00;
            int_phase <= 1'b0;
            ref_prev <= 1'b0;
        end
        else
        begin
            int_cnt <= next_int_cnt;
            int_phase <= next_int_phase;
            ref_prev <= reference_input;
        end
    end

    // start-up, run and source switching sequence
    always_comb
    begin
        next_state = state;
        next_sel_ext = sel_ext;
        next_stab_count = stab_count;
        next_break_cnt = break_cnt;
        next_gate_en = gate_en;
        unique case (state)
            ST_OFF:
            begin
                next_sel_ext = req_ext;
                next_gate_en = 1'b0;
                if (power_down_n)
                    next_state = ST_WAIT_OE;
            end
            ST_WAIT_OE:
            begin
                next_sel_ext = req_ext;
                next_stab_count = 9'h000;
                if (output_enable)
                    next_state = ST_STAB; // see RULE_01, see RULE_04
            end
            ST_STAB:
            begin
                if (master_tick)
                    next_stab_count = stab_count + 9'h001; // see RULE_03
                if (master_tick && stab_count == STAB_TICKS - 9'h001)
                    next_state = ST_RUN; // see RULE_05
            end
            ST_RUN:
            begin
                if (div_if.rise)
                    next_gate_en = output_enable; // see RULE_02, see RULE_07
                if (req_ext != sel_ext)
                begin
                    next_state = ST_BREAK;
                    next_break_cnt = 8'h00;
                    next_gate_en = 1'b0;
                end
            end
            ST_BREAK:
            begin
                if (break_cnt < INT_HALF_CYCLES)
                    next_break_cnt = break_cnt + 8'h01; // see RULE_06
                else if (req_tick)
                begin
                    next_sel_ext = req_ext;
                    next_state = ST_RUN;
                end
            end
        endcase
        if (!power_down_n)
            next_state = ST_OFF;
    end

    always_comb
    begin
        next_primary = (state == ST_RUN) && prim_if.level; // see RULE_04, see RULE_06
        next_gated = (state == ST_RUN) && div_if.level && gate_en; // see RULE_07
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            state <= ST_OFF;
            sel_ext <= 1'b0;
            stab_count <= 9'h000;
            break_cnt <= 8'h00;
            gate_en <= 1'b0;
            primary_clock_out <= 1'b0;
            gated_clock_out <= 1'b0;
            phase_state <= ST_OFF;
        end
        else
        begin
            state <= next_state;
            sel_ext <= next_sel_ext;
            stab_count <= next_stab_count;
            break_cnt <= next_break_cnt;
            gate_en <= next_gate_en;
            primary_clock_out <= next_primary;
            gated_clock_out <= next_gated;
            phase_state <= next_state;
        end
    end

    // helper: master ticks since stabilization start, saturating at 1023, and a flag set at the first divided rise
    logic [9:0] since_start;
    logic seen_div;
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || state == ST_WAIT_OE || state == ST_OFF)
        begin
            since_start <= 10'h000;
            seen_div <= 1'b0;
        end
        else
        begin
            if (master_tick && since_start != 10'h3ff)
                since_start <= since_start + 10'h001;
            if (div_if.rise)
                seen_div <= 1'b1;
        end
    end

    property p_wait_oe;
        @(posedge ref_clk) disable iff (sys_rst)
        (state == ST_WAIT_OE && !output_enable && power_down_n) |=> state == ST_WAIT_OE;
    endproperty
    a_wait_oe: assert property (p_wait_oe) else $error("stabilization began without enable"); // see RULE_01

    property p_gate_low;
        @(posedge ref_clk) disable iff (sys_rst)
        (state == ST_RUN && div_if.rise && !output_enable) |=> ##1 !gated_clock_out;
    endproperty
    a_gate_low: assert property (p_gate_low) else $error("gated output rose with enable low"); // see RULE_02

    property p_ext_count;
        @(posedge ref_clk) disable iff (sys_rst)
        (state == ST_STAB && sel_ext && !ext_tick && power_down_n)
            |=> stab_count == $past(stab_count);
    endproperty
    a_ext_count: assert property (p_ext_count) else $error("stab count moved without ext tick"); // see RULE_03

    property p_primary_waits;
        @(posedge ref_clk) disable iff (sys_rst)
        (state == ST_WAIT_OE || state == ST_OFF) |=> !primary_clock_out;
    endproperty
    a_primary_waits: assert property (p_primary_waits) else $error("primary ran before start"); // see RULE_04

    property p_first_rise;
        @(posedge ref_clk) disable iff (sys_rst)
        (!seen_div && state != ST_BREAK) |-> since_start <= {1'b0, FIRST_RISE_LIMIT};
    endproperty
    a_first_rise: assert property (p_first_rise) else $error("first rise later than 256 periods"); // see RULE_05

    sequence s_switch;
        state == ST_RUN && req_ext != sel_ext && power_down_n;
    endsequence
    sequence s_break_low;
        (state == ST_BREAK && !primary_clock_out) [*2];
    endsequence
    property p_break;
        @(posedge ref_clk) disable iff (sys_rst || !power_down_n)
        s_switch |=> ##1 s_break_low;
    endproperty
    a_break: assert property (p_break) else $error("source switch without low break"); // see RULE_06

    property p_gate_sync;
        @(posedge ref_clk) disable iff (sys_rst)
        (state == ST_RUN && $changed(gate_en) && gate_en) |-> $past(div_if.rise);
    endproperty
    a_gate_sync: assert property (p_gate_sync) else $error("gate opened off a divided rise"); // see RULE_07

    property p_gate_phase;
        @(posedge ref_clk) disable iff (sys_rst)
        $rose(gated_clock_out) |-> $past(div_if.rise, 2);
    endproperty
    a_gate_phase: assert property (p_gate_phase) else $error("gated output rose off phase"); // see RULE_07
endmodule : oscillator_output_gating
`default_nettype wire

// ==== verilog/osc_gating_pkg.sv ====
package osc_gating_pkg;

    // master oscillator model and timing, in ns and derived cycles
    localparam int CLK_PERIOD_NS = 40;
    localparam int INT_PERIOD_NS = 160;
    localparam int INT_HALF_CYCLES_I = (INT_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] INT_HALF_CYCLES = INT_HALF_CYCLES_I[7:0];

    // divider half periods, in master ticks
    localparam logic [7:0] PRIMARY_HALF = 8'h01;
    localparam logic [7:0] DIVIDED_HALF = 8'h02;

    // first rise of both outputs no later than this many master periods
    localparam logic [8:0] FIRST_RISE_LIMIT = 9'h100;
    localparam logic [8:0] STAB_TICKS = 9'h0fe;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_WAIT_OE,
        ST_STAB,
        ST_RUN,
        ST_BREAK
    } state_t;

endpackage : osc_gating_pkg

// ==== verilog/divider_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface divider_if;
    logic tick;
    logic clear;
    logic level;
    logic rise;
    modport ctrl (output tick, output clear, input level, input rise);
    modport div (input tick, input clear, output level, output rise);
endinterface : divider_if
`default_nettype wire

// ==== verilog/tick_divider.sv ====
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
    parameter logic [7:0] HALF = 8'h01
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    divider_if.div port
);
    logic [7:0] cnt;
    logic level;
    logic [7:0] next_cnt;
    logic next_level;
    logic wrap;

    assign wrap = (cnt == HALF - 8'h01);
    assign port.level = level;
    assign port.rise = port.tick && wrap && !level && !port.clear;

    always_comb
    begin
        next_cnt = cnt;
        next_level = level;
        if (port.clear)
        begin
            next_cnt = 8'h00;
            next_level = 1'b0;
        end
        else if (port.tick)
        begin
            next_cnt = wrap ? 8'h00 : cnt + 8'h01;
            next_level = wrap ? !level : level;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            cnt <= 8'h00;
            level <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            level <= next_level;
        end
    end
endmodule : tick_divider
`default_nettype wire

// ==== bench/ext_ref_source.sv ====
`timescale 1ns/10ps
`default_nettype none
module ext_ref_source (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic run,
    input wire logic [3:0] half,
    output logic reference_input
);
    logic [3:0] cnt;
    // stands low while not running
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || !run)
        begin
            cnt <= 4'h0;
            reference_input <= 1'b0;
        end
        else if (cnt + 4'h1 >= half)
        begin
            cnt <= 4'h0;
            reference_input <= !reference_input;
        end
        else
            cnt <= cnt + 4'h1;
    end
endmodule : ext_ref_source
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb;
    import osc_gating_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic power_down_n = 1'b0;
    logic output_enable = 1'b0;
    logic reference_select_n = 1'b1;
    logic ext_run = 1'b0;
    logic [3:0] half = 4'h2;
    logic reference_input;
    logic primary_clock_out;
    logic gated_clock_out;
    state_t phase_state;
    int fail_count = 0;
    int check_count = 0;
    int n, m, k, p, hl = 0;
    logic g_prev = 1'b0;
    logic mon = 1'b0;
    // set when a high phase saw the external source selected
    logic mixed = 1'b0;

    oscillator_output_gating dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .power_down_n(power_down_n), .output_enable(output_enable),
        .reference_select_n(reference_select_n), .reference_input(reference_input),
        .primary_clock_out(primary_clock_out), .gated_clock_out(gated_clock_out),
        .phase_state(phase_state));
    ext_ref_source far (.ref_clk(ref_clk), .sys_rst(sys_rst), .run(ext_run),
        .half(half), .reference_input(reference_input));

    always #20 ref_clk = ~ref_clk;

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick;
        @(posedge ref_clk);
    endtask : tick

    // clock cycles taken by a run of master ticks at a given master period
    function automatic int span(input int ticks, input int per);
        return ticks * per;
    endfunction : span

    // cycles until the chosen output is high, bounded
    task automatic wait_high(input int which, output int cnt);
        cnt = 0;
        while (((which == 0) ? primary_clock_out : gated_clock_out) !== 1'b1 && cnt < 3000)
        begin
            tick();
            cnt++;
        end
    endtask : wait_high

    task automatic power_up(input logic sel, input logic oe);
        power_down_n <= 1'b0;
        reference_select_n <= sel;
        output_enable <= oe;
        repeat (4) tick();
        power_down_n <= 1'b1;
    endtask : power_up

    // every monitored high phase of the gated clock in run on the internal source is whole
    always @(posedge ref_clk)
    begin
        if (gated_clock_out === 1'b1)
        begin
            hl = hl + 1;
            if (reference_select_n !== 1'b1)
                mixed = 1'b1;
        end
        else
        begin
            if (g_prev && mon && !mixed && reference_select_n === 1'b1 && phase_state === ST_RUN)
                check(hl, span(int'(DIVIDED_HALF), p));
            hl = 0;
            mixed = 1'b0;
        end
        g_prev = (gated_clock_out === 1'b1);
    end

    initial
    begin
        #(40 * 20000);
        fail_count++;
        report_and_stop();
    end

    initial
    begin
        p = 2 * int'(INT_HALF_CYCLES);
        void'($urandom(1));
        repeat (10) tick();
        sys_rst <= 1'b0;
        tick();
        power_up(1'b1, 1'b0);
        repeat (600) tick();
        check(32'(phase_state), 32'(ST_WAIT_OE));
        check(primary_clock_out, 1'b0);
        output_enable <= 1'b1;
        wait_high(0, n);
        wait_high(1, m);
        check(n >= span(int'(STAB_TICKS) - 2, p), 1'b1);
        check(n + m <= span(int'(FIRST_RISE_LIMIT), p) + 8, 1'b1);
        $display("test 1 done");
        mon <= 1'b1;
        k = 0;
        repeat (400)
        begin
            tick();
            if ($urandom % 12 == 0)
                output_enable <= !output_enable;
            k += (primary_clock_out === 1'b1);
        end
        check(k > 50, 1'b1);
        $display("test 2 done");
        power_up(1'b1, 1'b1);
        repeat (100) tick();
        output_enable <= 1'b0;
        wait_high(0, n);
        check(n <= span(int'(FIRST_RISE_LIMIT), p) + 8, 1'b1);
        k = 0;
        repeat (200)
        begin
            tick();
            k += (gated_clock_out === 1'b1);
        end
        check(k, 0);
        $display("test 3 done");
        output_enable <= 1'b1;
        half <= 4'(2 + $urandom % 3);
        ext_run <= 1'b1;
        for (int s = 0; s < 2; s++)
        begin
            repeat (40) tick();
            reference_select_n <= s[0];
            repeat (2) tick();
            check(32'(phase_state), 32'(ST_BREAK));
            n = 0;
            while (primary_clock_out === 1'b1 && n < 20)
            begin
                tick();
                n++;
            end
            wait_high(0, n);
            check(n >= int'(INT_HALF_CYCLES), 1'b1);
        end
        $display("test 4 done");
        mon <= 1'b0;
        power_up(1'b0, 1'b1);
        wait_high(0, n);
        m = 2 * int'(half);
        check(n >= span(int'(STAB_TICKS) - 1, m), 1'b1);
        check(n <= span(int'(FIRST_RISE_LIMIT) + 1, m) + 8, 1'b1);
        $display("test 5 done");
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
